// ---- bench/sccfg_host.sv ----
// Host model: byte writes and latch-read commands to the bank.
// Assumes one shared ref_clk; outputs change after the rising edge.
`timescale 1ns/1ps
module sccfg_host (
  input wire logic ref_clk,
  output sccfg_pkg::sccfg_wr_t reg_wr,
  output logic latch_read,
  output logic [7:0] latch_addr
);
  initial begin
    reg_wr = '0;
    latch_read = 1'b0;
    latch_addr = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= '{vld: 1'b1, addr: a, data: d};
    @(posedge ref_clk);
    reg_wr.vld <= 1'b0;
  endtask
  // Low byte first, then the committing high byte
  task automatic wr_gain(input logic sel, input logic [10:0] g);
    wr(sel ? 8'h16 : 8'h14, g[7:0]);
    wr(sel ? 8'h17 : 8'h15, {5'h00, g[10:8]});
  endtask
  task automatic latch(input logic [7:0] a);
    @(posedge ref_clk);
    latch_read <= 1'b1;
    latch_addr <= a;
    @(posedge ref_clk);
    latch_read <= 1'b0;
    latch_addr <= ~a;
  endtask
endmodule

// ---- bench/sincos_ctl_gain_config_bench.sv ----
// Self-checking bench for the gain and loop configuration bank.
// Assumes the host model drives writes and latch reads on ref_clk.
`timescale 1ns/1ps
module sincos_ctl_gain_config_bench;
  logic ref_clk, rst_n, samp_tick, latch_read, hold_vld;
  logic loop_run, timer_en, timer_tick;
  logic [7:0] latch_addr;
  logic [31:0] ext_rd_data, hold_data, gain_word, cfg_m, r;
  sccfg_pkg::sccfg_wr_t reg_wr;
  sccfg_pkg::sccfg_gupd_t ctl_gain_upd;
  sccfg_pkg::sccfg_cfg_t cfg_out;
  logic [1:0][12:0] raw_smp, off_corr;
  logic [1:0][15:0] corr_smp;
  logic [1:0] off_settle_shift, gain_settle_shift;
  logic signed [14:0] phase_trim_mdeg;
  logic [10:0] gm [2];
  int n_fail, compares, n, t, rv [2], ov [2];
  int dv [4] = '{4, 5, 10, 20};

  sccfg_top #(.TMR_F0_HZ(10_000_000), .TMR_F1_HZ(8_000_000),
    .TMR_F2_HZ(4_000_000), .TMR_F3_HZ(2_000_000)) i_sccfg_top (
    .ref_clk, .rst_n, .reg_wr, .latch_read, .latch_addr, .samp_tick,
    .ext_rd_data, .hold_data, .hold_vld, .ctl_gain_upd, .raw_smp,
    .off_corr, .corr_smp, .cfg_out, .gain_word, .loop_run,
    .off_settle_shift, .gain_settle_shift, .phase_trim_mdeg,
    .timer_en, .timer_tick);
  sccfg_host i_sccfg_host (.ref_clk, .reg_wr, .latch_read, .latch_addr);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic gchk();
    chk(gain_word, {5'h00, gm[1], 5'h00, gm[0]});
  endtask

  task automatic wcfg(input logic [31:0] w);
    for (int b = 0; b < 4; b++) i_sccfg_host.wr(8'(8'h10 + b), w[8*b +: 8]);
    cfg_m = w & 32'h7f1f_ffff;
    repeat (2) @(negedge ref_clk);
    t = $signed(cfg_m[29:24]);
    t = t > 20 ? 20 : t < -20 ? -20 : t;
    chk(cfg_out, cfg_m);
    chk(32'(loop_run), 32'(!cfg_m[16]));
    chk(32'(off_settle_shift), 32'(cfg_m[20:19]));
    chk(32'(gain_settle_shift), cfg_m[18] ? 3 : cfg_m[17] ? 2 : 0);
    chk(32'(phase_trim_mdeg), t * (cfg_m[30] ? 500 : 250));
    chk(32'(timer_en), 32'(cfg_m[9:0] != 0));
  endtask

  task automatic upd(input logic [10:0] s, input logic [10:0] c);
    @(posedge ref_clk);
    ctl_gain_upd <= '{1'b1, s, c};
    @(posedge ref_clk);
    ctl_gain_upd.vld <= 1'b0;
    @(negedge ref_clk);
    if (!cfg_m[16]) begin
      gm[1] = s;
      gm[0] = c;
    end
    gchk();
  endtask

  task automatic cap(input logic [7:0] a, input int tk, input int en,
      input logic [31:0] ed);
    i_sccfg_host.latch(a);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      samp_tick <= (n == tk);
      @(negedge ref_clk);
    end while (hold_vld !== 1'b1 && n < 40);
    chk(n, en);
    chk(hold_data, ed);
  endtask

  task automatic tmr(input int per);
    do @(negedge ref_clk); while (timer_tick !== 1'b1);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (timer_tick !== 1'b1 && n < 400);
    chk(n, per);
  endtask

  initial begin
    #400000;
    n_fail++;
    stop_test();
  end

  initial begin
    r = $urandom(32'h2c34);
    rst_n = 1'b0;
    samp_tick = 1'b0;
    ctl_gain_upd = '0;
    raw_smp = '0;
    off_corr = '0;
    ext_rd_data = $urandom();
    n_fail = 0;
    compares = 0;
    cfg_m = '0;
    gm[0] = 11'h400;
    gm[1] = 11'h400;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk(cfg_out, 32'h0000_0000);
    chk(32'(loop_run), 32'h0000_0001);
    chk(32'(timer_en), 32'h0000_0000);
    gchk();
    repeat (8) wcfg($urandom());
    for (int i = 0; i < 2; i++) begin
      r = $urandom();
      i_sccfg_host.wr(i ? 8'h16 : 8'h14, r[7:0]);
      @(negedge ref_clk);
      gchk();
      i_sccfg_host.wr(i ? 8'h17 : 8'h15, r[15:8]);
      gm[i] = r[10:0];
      @(negedge ref_clk);
      gchk();
    end
    i_sccfg_host.wr_gain(1'b0, 11'h7ff);
    gm[0] = 11'h7ff;
    @(negedge ref_clk);
    gchk();
    wcfg(32'h0001_0000);
    upd(11'($urandom()), 11'($urandom()));
    wcfg(32'h0000_0000);
    upd(11'($urandom()), 11'($urandom()));
    wcfg(32'h0000_8000);
    cap(8'h24, 0, 1, ext_rd_data);
    cap(8'h10, 0, 1, cfg_m);
    cap(8'h14, 0, 1, {5'h00, gm[1], 5'h00, gm[0]});
    wcfg(32'h0000_9000);
    cap(8'h24, 3, 1, ext_rd_data);
    wcfg(32'h0000_1000);
    cap(8'h2c, 3, 9, ext_rd_data);
    wcfg(32'h0000_0800);
    cap(8'h24, 3, 7, ext_rd_data);
    wcfg(32'h0000_0000);
    cap(8'h24, 3, 5, ext_rd_data);
    for (int b = 0; b < 4; b++) begin
      wcfg({22'h0, 2'(b), 8'h02});
      tmr(3 * dv[b]);
    end
    wcfg(32'h0000_0000);
    i_sccfg_host.wr_gain(1'b0, 11'h400);
    i_sccfg_host.wr_gain(1'b1, 11'h400);
    gm[0] = 11'h400;
    gm[1] = 11'h400;
    for (int k = 0; k < 8; k++) begin
      if (k == 4) upd(11'($urandom()), 11'($urandom()));
      @(posedge ref_clk);
      for (int j = 0; j < 2; j++) begin
        rv[j] = $urandom_range(8190) - 4095;
        ov[j] = $urandom_range(5459) - 2730;
        raw_smp[j] <= 13'(rv[j]);
        off_corr[j] <= 13'(ov[j]);
      end
      repeat (2) @(negedge ref_clk);
      for (int j = 0; j < 2; j++) begin
        t = ((2 * rv[j] + ov[j]) * (1024 + int'(gm[j]))) >>> 11;
        chk(32'($signed(corr_smp[j])), t);
      end
    end
    stop_test();
  end
endmodule

// ---- rtl/sccfg_corr.sv ----
// One channel of the gain and offset corrected sample path.
// Assumes raw and offset samples are stable on the reference clock.
`timescale 1ns/1ps
module sccfg_corr (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic signed [12:0] raw,
  input wire logic signed [12:0] off,
  input wire logic [10:0] gain,
  output logic signed [15:0] corr
);
  logic signed [14:0] sum;
  logic signed [12:0] fac;
  logic signed [27:0] prod;

  // Doubled raw plus offset, scaled by 0.5 + gain/2048
  assign sum = (15'(raw) <<< 1) + 15'(off);
  assign fac = $signed({1'b0, 12'(sccfg_pkg::GAIN_HALF + {1'b0, gain})});
  assign prod = 28'(sum * fac);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      corr <= '0;
    end else begin
      corr <= 16'(prod >>> sccfg_pkg::GAIN_FRAC_BITS);
    end
  end

  a_corr_unity: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (gain == sccfg_pkg::GC_RST) |=> (corr == 16'($past(sum))))
    else $error("unity gain does not pass the offset-corrected sample");

endmodule

// ---- rtl/sccfg_pkg.sv ----
// Constants and types for the sine/cosine gain and loop configuration bank.
// Assumes a byte-wide register write port and a latch-read strobe from the
// serial front end, all on the 40 MHz reference clock.
// Contract
// - Range bit: 0.25 or 0.5 degree steps
// - Signed trim bits 29-24, range -20..+20
// - Offset speed codes shorten settling 2/4/8
// - Gain speed codes shorten settling, default 00
// - Disable bit 16 stops the correction loop
// - Sync capture waits sample point plus shift
// - Capture_select_a capture loads at once, shift ignored
// - Timer period is (reload+1) base ticks
// - Base and reload both zero disable timer
// - Sine gain commits on 0x17 write
// - Cosine gain commits on 0x15 write
// - Running loop overwrites gain corrections itself
// - Corrected = (2raw+off)*(0.5+gain/2048), reset 0x400
// - Gain read as word, written by bytes
package sccfg_pkg;

  localparam int CLK_HZ = 40_000_000;

  localparam logic [7:0] CFG_B0 = 8'h10;
  localparam logic [7:0] GC_LO_C = 8'h14;
  localparam logic [7:0] GC_HI_C = 8'h15;
  localparam logic [7:0] GC_LO_S = 8'h16;
  localparam logic [7:0] GC_HI_S = 8'h17;

  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK = 32'h7F1F_FFFF;
  localparam logic [10:0] GC_RST = 11'h400;
  localparam int GC_HI_BITS = 3;
  localparam int GC_S_LSB = 16;

  localparam logic signed [5:0] PH_TRIM_MAX = 6'sd20;
  localparam logic signed [9:0] PH_STEP_FINE_MDEG = 10'sd250;
  localparam logic signed [9:0] PH_STEP_COARSE_MDEG = 10'sd500;

  localparam logic [11:0] GAIN_HALF = 12'h400;
  localparam int GAIN_FRAC_BITS = 11;

  typedef struct packed {
    logic rsv31;
    logic ph_range;
    logic signed [5:0] ph_trim;
    logic [2:0] rsv23;
    logic [1:0] off_spd;
    logic [1:0] gain_spd;
    logic loop_dis;
    logic cap_capture_select_a;
    logic [4:0] cap_shift;
    logic [1:0] tmr_base;
    logic [7:0] tmr_reload;
  } sccfg_cfg_t;

  typedef struct packed {
    logic vld;
    logic [7:0] addr;
    logic [7:0] data;
  } sccfg_wr_t;

  typedef struct packed {
    logic vld;
    logic [10:0] sin;
    logic [10:0] cos;
  } sccfg_gupd_t;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_WAIT = 2'b01,
    CAP_SHIFT = 2'b11,
    CAP_LOAD = 2'b10
  } sccfg_cap_t;

endpackage

// ---- rtl/sccfg_top.sv ----
// Gain correction and loop/capture configuration bank with timer and
// corrected sample path. Assumes the serial front end delivers byte
// writes, latch-read strobes and sample ticks on ref_clk.
`timescale 1ns/1ps
module sccfg_top #(
  parameter int TMR_F0_HZ = 1_000_000,
  parameter int TMR_F1_HZ = 100_000,
  parameter int TMR_F2_HZ = 10_000,
  parameter int TMR_F3_HZ = 1_000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire sccfg_pkg::sccfg_wr_t reg_wr,
  input wire logic latch_read,
  input wire logic [7:0] latch_addr,
  input wire logic samp_tick,
  input wire logic [31:0] ext_rd_data,
  output logic [31:0] hold_data,
  output logic hold_vld,
  input wire sccfg_pkg::sccfg_gupd_t ctl_gain_upd,
  input wire logic [1:0][12:0] raw_smp,
  input wire logic [1:0][12:0] off_corr,
  output logic [1:0][15:0] corr_smp,
  output sccfg_pkg::sccfg_cfg_t cfg_out,
  output logic [31:0] gain_word,
  output logic loop_run,
  output logic [1:0] off_settle_shift,
  output logic [1:0] gain_settle_shift,
  output logic signed [14:0] phase_trim_mdeg,
  output logic timer_en,
  output logic timer_tick
);
  localparam int TMR_DIV0 = sccfg_pkg::CLK_HZ / TMR_F0_HZ;
  localparam int TMR_DIV1 = sccfg_pkg::CLK_HZ / TMR_F1_HZ;
  localparam int TMR_DIV2 = sccfg_pkg::CLK_HZ / TMR_F2_HZ;
  localparam int TMR_DIV3 = sccfg_pkg::CLK_HZ / TMR_F3_HZ;

  function automatic logic hit(input sccfg_pkg::sccfg_wr_t w,
                               input logic [7:0] a);
    return w.vld && (w.addr == a);
  endfunction

  sccfg_pkg::sccfg_cfg_t cfg_q;
  logic [31:0] cfg_lane_d;
  logic [31:0] cfg_d;
  logic [10:0] gs_q, gs_d, gc_q, gc_d;
  logic [7:0] pend_s_q, pend_c_q;
  logic ctl_take;
  logic signed [5:0] trim_c;
  logic signed [9:0] ph_step;
  logic signed [14:0] phase_d;

  // Configuration word, byte lanes, unused bits forced low
  for (genvar gi = 0; gi < 4; gi++) begin : g_lane
    assign cfg_lane_d[8*gi +: 8] =
      hit(reg_wr, 8'(sccfg_pkg::CFG_B0 + gi)) ? reg_wr.data
                                                : cfg_q[8*gi +: 8];
  end
  assign cfg_d = cfg_lane_d & sccfg_pkg::CFG_WMASK;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= sccfg_pkg::CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end
  assign cfg_out = cfg_q;

  // Gain correction: low byte parks, high write commits
  assign ctl_take = ctl_gain_upd.vld && !cfg_q.loop_dis;
  assign gc_d = hit(reg_wr, sccfg_pkg::GC_HI_C) ?
                {reg_wr.data[sccfg_pkg::GC_HI_BITS-1:0], pend_c_q} :
                ctl_take ? ctl_gain_upd.cos : gc_q;
  assign gs_d = hit(reg_wr, sccfg_pkg::GC_HI_S) ?
                {reg_wr.data[sccfg_pkg::GC_HI_BITS-1:0], pend_s_q} :
                ctl_take ? ctl_gain_upd.sin : gs_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gc_q <= sccfg_pkg::GC_RST;
      gs_q <= sccfg_pkg::GC_RST;
      pend_c_q <= '0;
      pend_s_q <= '0;
    end else begin
      gc_q <= gc_d;
      gs_q <= gs_d;
      if (hit(reg_wr, sccfg_pkg::GC_LO_C)) begin
        pend_c_q <= reg_wr.data;
      end
      if (hit(reg_wr, sccfg_pkg::GC_LO_S)) begin
        pend_s_q <= reg_wr.data;
      end
    end
  end
  assign gain_word = {5'h00, gs_q, 5'h00, gc_q};

  // Loop controls
  assign loop_run = !cfg_q.loop_dis;
  assign off_settle_shift = cfg_q.off_spd;
  assign gain_settle_shift = (cfg_q.gain_spd == 2'b00) ? 2'd0 :
                             (cfg_q.gain_spd == 2'b01) ? 2'd2 : 2'd3;

  // Phase trim in millidegrees, clamped to the legal code range
  assign trim_c = (cfg_q.ph_trim > sccfg_pkg::PH_TRIM_MAX) ?
                  sccfg_pkg::PH_TRIM_MAX :
                  (cfg_q.ph_trim < -sccfg_pkg::PH_TRIM_MAX) ?
                  -sccfg_pkg::PH_TRIM_MAX : cfg_q.ph_trim;
  assign ph_step = cfg_q.ph_range ? sccfg_pkg::PH_STEP_COARSE_MDEG
                                  : sccfg_pkg::PH_STEP_FINE_MDEG;
  assign phase_d = 15'(trim_c * ph_step);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_trim_mdeg <= '0;
    end else begin
      phase_trim_mdeg <= phase_d;
    end
  end

  // Timer: prescaler picks base rate, counter runs reload+1 base ticks
  logic [15:0] pre_q, div_sel;
  logic [7:0] tmr_q;
  logic base_tick;

  assign timer_en = (cfg_q.tmr_base != 2'b00) ||
                    (cfg_q.tmr_reload != 8'h00);
  assign div_sel = (cfg_q.tmr_base == 2'd0) ? 16'(TMR_DIV0) :
                   (cfg_q.tmr_base == 2'd1) ? 16'(TMR_DIV1) :
                   (cfg_q.tmr_base == 2'd2) ? 16'(TMR_DIV2) :
                   16'(TMR_DIV3);
  // Compare by >= so a smaller base picked mid-count never wraps
  assign base_tick = timer_en && (pre_q >= 16'(div_sel - 16'd1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
      tmr_q <= '0;
      timer_tick <= 1'b0;
    end else if (!timer_en) begin
      pre_q <= '0;
      tmr_q <= '0;
      timer_tick <= 1'b0;
    end else begin
      pre_q <= base_tick ? 16'd0 : 16'(pre_q + 16'd1);
      timer_tick <= base_tick && (tmr_q == 8'h00);
      if (base_tick) begin
        tmr_q <= (tmr_q == 8'h00) ? cfg_q.tmr_reload
                                  : 8'(tmr_q - 8'd1);
      end
    end
  end

  // Read capture into the holding register
  sccfg_pkg::sccfg_cap_t st_q, st_d;
  logic [4:0] sh_q;
  logic [7:0] cap_addr_q;
  logic [31:0] rd_sel;
  logic cap_start;

  assign cap_start = latch_read && (st_q == sccfg_pkg::CAP_IDLE);
  assign rd_sel = (cap_addr_q == sccfg_pkg::CFG_B0) ? cfg_q :
                  (cap_addr_q == sccfg_pkg::GC_LO_C) ? gain_word :
                  ext_rd_data;

  always_comb begin
    st_d = st_q;
    case (st_q)
      sccfg_pkg::CAP_IDLE: begin
        if (cap_start) begin
          st_d = cfg_q.cap_capture_select_a ? sccfg_pkg::CAP_LOAD
                                 : sccfg_pkg::CAP_WAIT;
        end
      end
      sccfg_pkg::CAP_WAIT: begin
        if (samp_tick) begin
          st_d = (cfg_q.cap_shift == 5'd0) ? sccfg_pkg::CAP_LOAD
                                           : sccfg_pkg::CAP_SHIFT;
        end
      end
      sccfg_pkg::CAP_SHIFT: begin
        if (sh_q == 5'd1) begin
          st_d = sccfg_pkg::CAP_LOAD;
        end
      end
      sccfg_pkg::CAP_LOAD: st_d = sccfg_pkg::CAP_IDLE;
      default: st_d = sccfg_pkg::CAP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= sccfg_pkg::CAP_IDLE;
      sh_q <= '0;
      cap_addr_q <= '0;
      hold_data <= '0;
      hold_vld <= 1'b0;
    end else begin
      st_q <= st_d;
      hold_vld <= (st_q == sccfg_pkg::CAP_LOAD);
      if (cap_start) begin
        cap_addr_q <= latch_addr;
      end
      if (st_q == sccfg_pkg::CAP_WAIT && samp_tick) begin
        sh_q <= cfg_q.cap_shift;
      end else if (st_q == sccfg_pkg::CAP_SHIFT) begin
        sh_q <= 5'(sh_q - 5'd1);
      end
      if (st_q == sccfg_pkg::CAP_LOAD) begin
        hold_data <= rd_sel;
      end
    end
  end

  // Corrected samples, index 0 cosine, index 1 sine
  logic [1:0][10:0] gain_a;
  assign gain_a = {gs_q, gc_q};

  for (genvar gc = 0; gc < 2; gc++) begin : g_corr
    sccfg_corr u_corr (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .raw(raw_smp[gc]),
      .off(off_corr[gc]),
      .gain(gain_a[gc]),
      .corr(corr_smp[gc])
    );
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_capture_select_a_go;
    cap_start && cfg_q.cap_capture_select_a;
  endsequence

  sequence s_load_out;
    (st_q == sccfg_pkg::CAP_LOAD) ##1 hold_vld;
  endsequence

  a_capture_select_a_load: assert property (
    s_capture_select_a_go |=> s_load_out)
    else $error("capture_select_a latch did not load on the next cycle");

  a_sync_wait: assert property (
    (cap_start && !cfg_q.cap_capture_select_a) |=>
    (st_q == sccfg_pkg::CAP_WAIT) && !hold_vld)
    else $error("sync latch did not wait for the sample point");

  a_shift_delay: assert property (
    (st_q == sccfg_pkg::CAP_WAIT && samp_tick && cfg_q.cap_shift == 5'd2)
    |=> (st_q == sccfg_pkg::CAP_SHIFT) [*2] ##1 s_load_out)
    else $error("capture shift of two not honoured");

  a_cos_commit: assert property (
    hit(reg_wr, sccfg_pkg::GC_HI_C) |=>
    gc_q == {$past(reg_wr.data[2:0]), $past(pend_c_q)})
    else $error("cosine gain not committed on high byte write");

  a_sin_park: assert property (
    (hit(reg_wr, sccfg_pkg::GC_LO_S) && !ctl_take) |=> $stable(gs_q))
    else $error("sine gain changed on low byte write");

  a_loop_block: assert property (
    (cfg_q.loop_dis && ctl_gain_upd.vld && !reg_wr.vld) |=>
    $stable(gs_q) && $stable(gc_q))
    else $error("stopped loop still updated gain");

  a_timer_off: assert property (
    !timer_en |=> !timer_tick)
    else $error("timer ticked while disabled");

  a_reserved_zero: assert property (
    cfg_q.rsv31 == 1'b0 && cfg_q.rsv23 == 3'b000 &&
    gain_word[31:27] == 5'h00 && gain_word[15:11] == 5'h00)
    else $error("unused bits read as one");

  a_phase_bound: assert property (
    !cfg_q.ph_range && $stable(cfg_q) |=>
    phase_trim_mdeg <= 15'sd5000 && phase_trim_mdeg >= -15'sd5000)
    else $error("fine phase range exceeds five degrees");

  a_sin_commit: assert property (
    hit(reg_wr, sccfg_pkg::GC_HI_S) |=>
    gs_q == {$past(reg_wr.data[2:0]), $past(pend_s_q)})
    else $error("sine gain not committed on high byte write");

  a_cos_park: assert property (
    (hit(reg_wr, sccfg_pkg::GC_LO_C) && !ctl_take) |=> $stable(gc_q))
    else $error("cosine gain changed on low byte write");

  a_capture_select_a_data: assert property (
    s_capture_select_a_go |-> ##2 (hold_data == $past(rd_sel)))
    else $error("capture_select_a latch did not load the addressed word");

  a_timer_reload: assert property (
    timer_tick && $stable(cfg_q) |-> tmr_q == cfg_q.tmr_reload)
    else $error("timer did not reload after its period");

  a_trim_range: assert property (
    $stable(cfg_q) |=>
    phase_trim_mdeg <= 15'sd10000 && phase_trim_mdeg >= -15'sd10000)
    else $error("phase trim exceeds the coarse range");

endmodule
